// ---- src/burst_sram_mem.sv ----
// Purpose: device end: two-word burst static ram on the pin interface
// Assumes: link clocks sampled by clock_in through two flip-flops
// Notes:   lane masks and write data caught on each input clock rise
`timescale 1ns/100ps
module burst_sram_mem #(
  parameter int ADDR_W = burst_sram_pkg::ADDR_W,
  parameter int LANES  = burst_sram_pkg::LANES
) (
  input  wire logic   clock_in,
  input  wire logic   srst_in,
  burst_sram_if.mem   pins,
  output logic        busy_out
);
  localparam int DW = burst_sram_pkg::LANE_W * LANES;
  initial begin
    if (LANES != 1 && LANES != 2 && LANES != 4) begin
      $error("lanes must be 1, 2 or 4");
    end
  end

  typedef enum logic [2:0] {
    RD_IDLE  = 3'b000,
    RD_WAIT  = 3'b001,
    RD_GAP   = 3'b010,
    RD_WORD0 = 3'b011,
    RD_WORD1 = 3'b100
  } rd_state_t;

  logic [DW-1:0] mem_r [2**(ADDR_W+1)];
  logic [3:0] kp_sync_r, kn_sync_r, cp_sync_r, cn_sync_r;
  logic [1:0] pll_sync_r;
  localparam int CW = 2 + ADDR_W + DW + LANES;
  logic [CW-1:0]     cmd_s0_r, cmd_s1_r, cmd_s2_r;
  logic              smp_fetch_n, smp_store_n;
  logic [ADDR_W-1:0] smp_addr;
  logic [DW-1:0]     smp_wdata;
  logic [LANES-1:0]  smp_mask_n;
  logic       k_rise, kn_rise, c_rise, cn_rise, use_k;
  logic       launch_neg, launch_pos;
  logic       wr_pend_r;
  logic [ADDR_W-1:0] wr_addr_r, rd_addr_r;
  rd_state_t  rd_state_r;
  logic       powered_r;

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_v,
                                          input logic [DW-1:0] new_v,
                                          input logic [LANES-1:0] m_n);
    logic [DW-1:0] r;
    r = old_v;
    for (int i = 0; i < LANES; i++) begin
      if (!m_n[i]) begin
        r[i*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W] =
          new_v[i*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling: bits [1:0] synchronise, [3:2] find edges
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      kp_sync_r  <= 4'h0;
      kn_sync_r  <= 4'h0;
      cp_sync_r  <= 4'h0;
      cn_sync_r  <= 4'h0;
      pll_sync_r <= 2'h0;
      cmd_s0_r   <= '1;
      cmd_s1_r   <= '1;
      cmd_s2_r   <= '1;
    end else begin
      kp_sync_r  <= {kp_sync_r[2:0], pins.clk_pos};
      kn_sync_r  <= {kn_sync_r[2:0], pins.clk_neg};
      cp_sync_r  <= {cp_sync_r[2:0], pins.out_clk_pos};
      cn_sync_r  <= {cn_sync_r[2:0], pins.out_clk_neg};
      pll_sync_r <= {pll_sync_r[0], pins.pll_off_n};
      cmd_s0_r   <= {pins.fetch_sel_n, pins.store_sel_n, pins.addr[ADDR_W-1:0],
                     pins.wdata[DW-1:0], pins.lane_mask_n[LANES-1:0]};
      cmd_s1_r   <= cmd_s0_r;
      cmd_s2_r   <= cmd_s1_r;
    end
  end

  // command and data ride the same delay as the clocks, so stage 2 lines up with the edge
  assign {smp_fetch_n, smp_store_n, smp_addr, smp_wdata, smp_mask_n} = cmd_s2_r;

  assign k_rise  = kp_sync_r[2] & ~kp_sync_r[3];
  assign kn_rise = kn_sync_r[2] & ~kn_sync_r[3];
  assign c_rise  = cp_sync_r[2] & ~cp_sync_r[3];
  assign cn_rise = cn_sync_r[2] & ~cn_sync_r[3];
  // both output clocks high: fall back to the input pair
  assign use_k      = cp_sync_r[2] & cn_sync_r[2];
  assign launch_neg = use_k ? kn_rise : cn_rise;
  assign launch_pos = use_k ? k_rise : c_rise;

  ////////////////////////////////////////////////////////////////////////////
  // write machine: a high store select at the k rise leaves the array untouched; the second word is written at the next kn rise only after a low store select
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else if (k_rise) begin
      wr_pend_r <= !smp_store_n;
      if (!smp_store_n) begin
        wr_addr_r <= smp_addr;
      end
    end else if (kn_rise && wr_pend_r) begin
      wr_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (k_rise && !smp_store_n) begin
      mem_r[{smp_addr, 1'b0}] <= merge(mem_r[{smp_addr, 1'b0}],
                                       smp_wdata, smp_mask_n);
    end else if (kn_rise && wr_pend_r) begin
      mem_r[{wr_addr_r, 1'b1}] <= merge(mem_r[{wr_addr_r, 1'b1}],
                                        smp_wdata, smp_mask_n);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read machine: t+1 output-neg rise gives +0, t+2 output-pos gives +1
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rd_state_r <= RD_IDLE;
      rd_addr_r  <= '0;
    end else begin
      case (rd_state_r)
        RD_IDLE: begin
          if (k_rise && !smp_fetch_n) begin
            rd_state_r <= RD_WAIT;
            rd_addr_r  <= smp_addr;
          end
        end
        // the negative rise of cycle t is skipped; the next positive rise opens t+1
        RD_WAIT: begin
          if (launch_pos) begin
            rd_state_r <= RD_GAP;
          end
        end
        RD_GAP: begin
          if (launch_neg) begin
            rd_state_r <= RD_WORD0;
          end
        end
        RD_WORD0: begin
          if (launch_pos) begin
            rd_state_r <= RD_WORD1;
          end
        end
        RD_WORD1: begin
          if (launch_neg) begin
            rd_state_r <= RD_IDLE;
          end
        end
        default: rd_state_r <= RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      powered_r       <= 1'b0;
      pins.rdata_oe_n <= 1'b1;
      pins.rdata_o    <= '0;
    end else begin
      powered_r <= 1'b1;
      if (rd_state_r == RD_GAP && launch_neg && powered_r) begin
        pins.rdata_o    <= mem_r[{rd_addr_r, 1'b0}];
        pins.rdata_oe_n <= 1'b0;
      end else if (rd_state_r == RD_WORD0 && launch_pos) begin
        pins.rdata_o    <= mem_r[{rd_addr_r, 1'b1}];
      end else if (rd_state_r == RD_WORD1 && launch_neg) begin
        pins.rdata_oe_n <= 1'b1;
      end
    end
  end

  // echo strobes follow the launch clocks whether or not data is driven
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pins.echo_strobe_pos <= 1'b0;
      pins.echo_strobe_neg <= 1'b0;
    end else begin
      pins.echo_strobe_pos <= use_k ? kp_sync_r[2] : cp_sync_r[2];
      pins.echo_strobe_neg <= use_k ? kn_sync_r[2] : cn_sync_r[2];
    end
  end

  assign busy_out = wr_pend_r | (rd_state_r != RD_IDLE);
endmodule

// ---- src/burst_sram_pkg.sv ----
// Purpose: shared constants for the two-word burst sram link
// Assumes: link clocks are sampled by a 20 MHz system clock
// Notes:   widths are defaults; ends may override by parameter
package burst_sram_pkg;
  localparam int ADDR_W        = 8;
  localparam int LANE_W        = 9;
  localparam int LANES         = 4;
  localparam int DATA_W        = LANE_W * LANES;
  localparam int BURST_LEN     = 2;
  localparam int CLK_MHZ       = 20;
  localparam int LOCK_TIME_US  = 20;
  localparam int LOCK_CYCLES   = LOCK_TIME_US * CLK_MHZ + 1;
  localparam int NOP_COUNT     = 4;
  localparam int LINK_DIV      = 4;
  localparam int READ_LAT_HALF = 2;
  localparam int RD_CAP_FIRST  = 13;
  localparam int RD_CAP_LAST   = 15;
endpackage

// ---- src/burst_sram_if.sv ----
// Purpose: pins between memory controller and burst sram
// Assumes: released read data pins read as zero
// Notes:   oe_n low means the device drives the read data pins
`timescale 1ns/100ps
interface burst_sram_if;
  logic                                   clk_pos;
  logic                                   clk_neg;
  logic                                   out_clk_pos;
  logic                                   out_clk_neg;
  logic                                   pll_off_n;
  logic                                   fetch_sel_n;
  logic                                   store_sel_n;
  logic [burst_sram_pkg::ADDR_W-1:0]      addr;
  logic [burst_sram_pkg::DATA_W-1:0]      wdata;
  logic [burst_sram_pkg::LANES-1:0]       lane_mask_n;
  logic [burst_sram_pkg::DATA_W-1:0]      rdata_o;
  logic                                   rdata_oe_n;
  logic                                   echo_strobe_pos;
  logic                                   echo_strobe_neg;
  wire  [burst_sram_pkg::DATA_W-1:0]      rdata;
  assign rdata = rdata_oe_n ? '0 : rdata_o;
  modport ctrl (output clk_pos, clk_neg, out_clk_pos, out_clk_neg, pll_off_n,
                fetch_sel_n, store_sel_n, addr, wdata, lane_mask_n,
                input rdata, echo_strobe_pos, echo_strobe_neg);
  modport mem  (input clk_pos, clk_neg, out_clk_pos, out_clk_neg, pll_off_n,
                fetch_sel_n, store_sel_n, addr, wdata, lane_mask_n,
                output rdata_o, rdata_oe_n, echo_strobe_pos, echo_strobe_neg);
endinterface

// ---- src/pair_buffer.sv ----
// Purpose: two-entry valid/ready buffer
// Assumes: single clock
// Notes:   full and empty are exact
`timescale 1ns/100ps
module pair_buffer #(
  parameter int WIDTH = 36
) (
  input  wire logic             clock_in,
  input  wire logic             srst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  logic [WIDTH-1:0] mem_r [2];
  logic             wp_r;
  logic             rp_r;
  logic [1:0]       cnt_r;
  logic             push;
  logic             pop;

  assign in_ready_out  = (cnt_r != 2'h2);
  assign out_valid_out = (cnt_r != 2'h0);
  assign out_data_out  = mem_r[rp_r];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always_ff @(posedge clock_in) begin
    if (push) begin
      mem_r[wp_r] <= in_data_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ---- src/burst_sram_ctrl.sv ----
// Purpose: controller end: power-on sequence, two-word reads and writes
// Assumes: link clocks made by dividing clock_in
// Notes:   read words pass a two-entry buffer before the user port
`timescale 1ns/100ps
module burst_sram_ctrl #(
  parameter int ADDR_W      = burst_sram_pkg::ADDR_W,
  parameter int LOCK_CYCLES = burst_sram_pkg::LOCK_CYCLES
) (
  input  wire logic                               clock_in,
  input  wire logic                               srst_in,
  burst_sram_if.ctrl                              pins,
  input  wire logic                               req_valid_in,
  output logic                                    req_ready_out,
  input  wire logic                               req_write_in,
  input  wire logic [ADDR_W-1:0]                  req_addr_in,
  input  wire logic [2*burst_sram_pkg::DATA_W-1:0] req_wdata_in,
  input  wire logic [2*burst_sram_pkg::LANES-1:0]  req_mask_n_in,
  output logic                                    rd_valid_out,
  input  wire logic                               rd_ready_in,
  output logic [burst_sram_pkg::DATA_W-1:0]       rd_data_out,
  output logic                                    init_done_out
);
  localparam int DW = burst_sram_pkg::DATA_W;
  localparam int LN = burst_sram_pkg::LANES;
  initial begin
    if (LOCK_CYCLES < 1) begin
      $error("lock count too small");
    end
  end

  typedef enum logic [1:0] {
    C_LOCK = 2'b00,
    C_NOP  = 2'b01,
    C_RUN  = 2'b10
  } ctl_state_t;

  ctl_state_t  st_r;
  logic [31:0] cnt_r;
  logic [1:0]  div_r;
  logic        ph_pos, ph_neg;
  logic        wr_beat_r, rd_busy_r;
  logic [3:0]  rd_wait_r;
  logic [DW-1:0] wdata_hi_r;
  logic [LN-1:0] mask_hi_r;
  logic [1:0]  echo_sync_r, echo_n_sync_r;
  logic [DW-1:0] rdq_s_r, rdq_r;
  logic        buf_ready, cap;

  // link clock: divide by four; pos rises at div 0, neg at div 2
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end
  assign ph_pos = (div_r == 2'h3);
  assign ph_neg = (div_r == 2'h1);

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pins.clk_pos     <= 1'b0;
      pins.clk_neg     <= 1'b1;
      pins.out_clk_pos <= 1'b1;
      pins.out_clk_neg <= 1'b1;
      pins.pll_off_n   <= 1'b1;
    end else begin
      pins.clk_pos     <= ~div_r[1];
      pins.clk_neg     <= div_r[1];
      pins.out_clk_pos <= 1'b1;
      pins.out_clk_neg <= 1'b1;
      pins.pll_off_n   <= 1'b1;
    end
  end

  // power-on: lock wait, then nops, then run
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      st_r  <= C_LOCK;
      cnt_r <= '0;
    end else begin
      case (st_r)
        C_LOCK: begin
          cnt_r <= cnt_r + 32'h1;
          if (cnt_r >= 32'(LOCK_CYCLES)) begin
            st_r  <= C_NOP;
            cnt_r <= '0;
          end
        end
        C_NOP: begin
          if (ph_pos) begin
            cnt_r <= cnt_r + 32'h1;
          end
          if (cnt_r >= 32'(burst_sram_pkg::NOP_COUNT)) begin
            st_r <= C_RUN;
          end
        end
        C_RUN:   st_r <= C_RUN;
        default: st_r <= C_LOCK;
      endcase
    end
  end
  assign init_done_out = (st_r == C_RUN);

  // a new command waits for an empty buffer so both returning words fit
  assign req_ready_out = init_done_out & ph_pos & ~wr_beat_r & ~rd_busy_r & buf_ready &
                         ~rd_valid_out;

  ////////////////////////////////////////////////////////////////////////////
  // command pins change one clock before the positive link rise
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pins.fetch_sel_n <= 1'b1;
      pins.store_sel_n <= 1'b1;
      pins.addr        <= '0;
      pins.wdata       <= '0;
      pins.lane_mask_n <= '1;
      wr_beat_r        <= 1'b0;
      wdata_hi_r       <= '0;
      mask_hi_r        <= '1;
    end else if (req_valid_in && req_ready_out) begin
      pins.addr        <= req_addr_in;
      pins.fetch_sel_n <= req_write_in;
      pins.store_sel_n <= ~req_write_in;
      pins.wdata       <= req_wdata_in[DW-1:0];
      pins.lane_mask_n <= req_mask_n_in[LN-1:0];
      wdata_hi_r       <= req_wdata_in[2*DW-1:DW];
      mask_hi_r        <= req_mask_n_in[2*LN-1:LN];
      wr_beat_r        <= req_write_in;
    end else if (wr_beat_r && ph_neg) begin
      pins.wdata       <= wdata_hi_r;
      pins.lane_mask_n <= mask_hi_r;
      pins.store_sel_n <= 1'b1;
      wr_beat_r        <= 1'b0;
    end else if (ph_neg) begin
      pins.fetch_sel_n <= 1'b1;
      pins.store_sel_n <= 1'b1;
    end
  end

  // read return: words arrive a fixed count after the command, each beat
  // qualified by its synchronised echo strobe
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      echo_sync_r   <= 2'h0;
      echo_n_sync_r <= 2'h0;
      rdq_s_r       <= '0;
      rdq_r         <= '0;
      rd_busy_r     <= 1'b0;
      rd_wait_r     <= 4'h0;
    end else begin
      echo_sync_r   <= {echo_sync_r[0], pins.echo_strobe_pos};
      echo_n_sync_r <= {echo_n_sync_r[0], pins.echo_strobe_neg};
      rdq_s_r       <= pins.rdata;
      rdq_r         <= rdq_s_r;
      if (req_valid_in && req_ready_out && !req_write_in) begin
        rd_busy_r <= 1'b1;
        rd_wait_r <= 4'h0;
      end else if (rd_busy_r) begin
        rd_wait_r <= rd_wait_r + 4'h1;
        if (rd_wait_r == 4'(burst_sram_pkg::RD_CAP_LAST)) begin
          rd_busy_r <= 1'b0;
        end
      end
    end
  end
  assign cap = rd_busy_r &
               ((rd_wait_r == 4'(burst_sram_pkg::RD_CAP_FIRST) & echo_n_sync_r[1]) |
                (rd_wait_r == 4'(burst_sram_pkg::RD_CAP_LAST) & echo_sync_r[1]));

  pair_buffer #(.WIDTH(DW)) rd_buf (
    .clock_in      (clock_in),
    .srst_in       (srst_in),
    .in_valid_in   (cap),
    .in_ready_out  (buf_ready),
    .in_data_in    (rdq_r),
    .out_valid_out (rd_valid_out),
    .out_ready_in  (rd_ready_in),
    .out_data_out  (rd_data_out)
  );
endmodule

// ---- test/burst_sram_chk.sv ----
// Purpose: wire-level checks between the controller end and the device end
// Assumes: clock_in samples the link clocks; one clock domain
// Notes:   instantiated beside the interface by the testbench, no bind
`timescale 1ns/100ps
module burst_sram_chk #(
  parameter int LOCK_CYCLES = burst_sram_pkg::LOCK_CYCLES
) (
  input  wire logic                              clock_in,
  input  wire logic                              srst_in,
  input  wire logic                              clk_pos,
  input  wire logic                              clk_neg,
  input  wire logic                              pll_off_n,
  input  wire logic                              fetch_sel_n,
  input  wire logic                              store_sel_n,
  input  wire logic [burst_sram_pkg::ADDR_W-1:0] addr,
  input  wire logic [burst_sram_pkg::DATA_W-1:0] wdata,
  input  wire logic [burst_sram_pkg::LANES-1:0]  lane_mask_n,
  input  wire logic                              rdata_oe_n,
  input  wire logic                              echo_strobe_pos
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  logic pos_q;
  logic pos_rise;
  int   since_fetch;
  int   lock_cnt;
  int   nops;

  ////////////////////////////////////////////////////////////////////////////
  assign pos_rise = clk_pos & ~pos_q;

  always_ff @(posedge clock_in) begin
    pos_q <= clk_pos;
  end

  // cycles since the last read command, saturating
  always_ff @(posedge clock_in) begin
    if (srst_in) since_fetch <= 99;
    else if (pos_rise && !fetch_sel_n) since_fetch <= 0;
    else if (since_fetch < 99) since_fetch <= since_fetch + 1;
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) lock_cnt <= 0;
    else if (lock_cnt < LOCK_CYCLES) lock_cnt <= lock_cnt + 1;
  end

  // idle command cycles seen once the lock time has run out
  always_ff @(posedge clock_in) begin
    if (srst_in) nops <= 0;
    else if (pos_rise && fetch_sel_n && store_sel_n && lock_cnt == LOCK_CYCLES && nops < 4)
      nops <= nops + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  oe_reset_a: assert property (disable iff (1'b0) srst_in |=> rdata_oe_n)
    else $error("read pins driven during reset");
  pll_high_a: assert property (pll_off_n)
    else $error("pll disable driven low");
  boot_order_a: assert property (pos_rise && !(fetch_sel_n && store_sel_n) |-> nops == 4)
    else $error("access before lock time and idle cycles");
  read_lat_a: assert property ($rose(clk_pos) && !fetch_sel_n |-> ##[4:14] !rdata_oe_n)
    else $error("read data not driven in time");
  no_stray_a: assert property (!rdata_oe_n |-> since_fetch <= 18)
    else $error("read pins driven without a read");
  ctrl_setup_a: assert property ($rose(clk_pos) |-> $stable(fetch_sel_n) && $stable(store_sel_n)
                                 && $stable(addr))
    else $error("controls move at the sampling edge");
  beat_stable_a: assert property ($rose(clk_neg) |-> $stable(wdata) && $stable(lane_mask_n))
    else $error("second beat moves at its edge");
  echo_runs_a: assert property ($rose(clk_pos) |-> ##[1:6] $changed(echo_strobe_pos))
    else $error("echo strobe not running");

  rd_seen_c: cover property ($rose(clk_pos) && !fetch_sel_n);
  wr_seen_c: cover property ($rose(clk_pos) && !store_sel_n);
  lane_mix_c: cover property ($rose(clk_neg) && !(&lane_mask_n) && (|lane_mask_n));
  drive_seen_c: cover property ($fell(rdata_oe_n));
endmodule

// ---- test/quad_rate_burst2_sram_port_tb.sv ----
// Purpose: joins controller and device ends; checks writes, reads, stalls, reset
// Assumes: lock count shortened to 20 for simulation
// Notes:   expected words come from a shadow copy of the array
`timescale 1ns/100ps
module quad_rate_burst2_sram_port_tb;
  localparam int LOCK = 20;
  localparam int AW   = burst_sram_pkg::ADDR_W;
  localparam int DW   = burst_sram_pkg::DATA_W;
  typedef struct packed {
    logic            wr;
    logic [AW-1:0]   a;
    logic [2*DW-1:0] d;
    logic [7:0]      m;
  } row_t;

  logic            clock_in      = 1'b0;
  logic            srst_in       = 1'b1;
  logic            req_valid_in  = 1'b0;
  logic            req_write_in  = 1'b0;
  logic [AW-1:0]   req_addr_in   = '0;
  logic [2*DW-1:0] req_wdata_in  = '0;
  logic [7:0]      req_mask_n_in = 8'hFF;
  logic            rd_ready_in   = 1'b1;
  logic            req_ready_out;
  logic            rd_valid_out;
  logic [DW-1:0]   rd_data_out;
  logic            init_done_out;
  logic [DW-1:0]   shadow [0:2**(AW+1)-1];
  int              fails         = 0;
  int              checks_done   = 0;
  row_t            rows [0:10]   = '{
    '{1'b1, 8'h00, 72'h0F0E0D0C0B0A090807, 8'h00},
    '{1'b1, 8'h01, 72'h111111111222222222, 8'h00},
    '{1'b1, 8'h02, 72'h333333333444444444, 8'h00},
    '{1'b1, 8'hFF, 72'h5A5A5A5A5A5A5A5A5A, 8'h00},
    '{1'b1, 8'h01, 72'hABCDEF012345678ABC, 8'h7E},
    '{1'b1, 8'h02, 72'hFEDCBA987654321FED, 8'hBD},
    '{1'b1, 8'h00, 72'hFFFFFFFFFFFFFFFFFF, 8'hFF},
    '{1'b0, 8'h00, 72'h0, 8'h00},
    '{1'b0, 8'h01, 72'h0, 8'h00},
    '{1'b0, 8'h02, 72'h0, 8'h00},
    '{1'b0, 8'hFF, 72'h0, 8'h00}};

  always #25 clock_in = ~clock_in;

  ////////////////////////////////////////////////////////////////////////////
  burst_sram_if i_burst_sram_if ();

  burst_sram_mem i_burst_sram_mem (
    .clock_in (clock_in),
    .srst_in  (srst_in),
    .pins     (i_burst_sram_if.mem),
    .busy_out ()
  );

  burst_sram_ctrl #(.LOCK_CYCLES(LOCK)) i_burst_sram_ctrl (
    .clock_in      (clock_in),
    .srst_in       (srst_in),
    .pins          (i_burst_sram_if.ctrl),
    .req_valid_in  (req_valid_in),
    .req_ready_out (req_ready_out),
    .req_write_in  (req_write_in),
    .req_addr_in   (req_addr_in),
    .req_wdata_in  (req_wdata_in),
    .req_mask_n_in (req_mask_n_in),
    .rd_valid_out  (rd_valid_out),
    .rd_ready_in   (rd_ready_in),
    .rd_data_out   (rd_data_out),
    .init_done_out (init_done_out)
  );

  burst_sram_chk #(.LOCK_CYCLES(LOCK)) i_burst_sram_chk (
    .clock_in        (clock_in),
    .srst_in         (srst_in),
    .clk_pos         (i_burst_sram_if.clk_pos),
    .clk_neg         (i_burst_sram_if.clk_neg),
    .pll_off_n       (i_burst_sram_if.pll_off_n),
    .fetch_sel_n     (i_burst_sram_if.fetch_sel_n),
    .store_sel_n     (i_burst_sram_if.store_sel_n),
    .addr            (i_burst_sram_if.addr),
    .wdata           (i_burst_sram_if.wdata),
    .lane_mask_n     (i_burst_sram_if.lane_mask_n),
    .rdata_oe_n      (i_burst_sram_if.rdata_oe_n),
    .echo_strobe_pos (i_burst_sram_if.echo_strobe_pos)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (fails == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic expire(input int n);
    if (n >= 2000) begin
      fails++;
      $display("mismatch at %0t: wait ran out", $time);
      give_verdict();
    end
  endtask

  // holds the request until the edge at which ready is seen high
  task automatic send(input row_t r);
    int n;
    @(posedge clock_in);
    req_valid_in  <= 1'b1;
    req_write_in  <= r.wr;
    req_addr_in   <= r.a;
    req_wdata_in  <= r.d;
    req_mask_n_in <= r.m;
    @(negedge clock_in);
    for (n = 0; n < 2000 && req_ready_out !== 1'b1; n++) @(negedge clock_in);
    expire(n);
    @(posedge clock_in);
    req_valid_in <= 1'b0;
    if (r.wr)
      for (int i = 0; i < 8; i++)
        if (!r.m[i]) shadow[{r.a, i[2]}][(i%4)*9 +: 9] = r.d[i*9 +: 9];
  endtask

  task automatic take(input logic [AW-1:0] a);
    int n;
    for (int b = 0; b < 2; b++) begin
      @(negedge clock_in);
      for (n = 0; n < 2000 && rd_valid_out !== 1'b1; n++) @(negedge clock_in);
      expire(n);
      cmp_word(rd_data_out, shadow[{a, b[0]}]);
      @(posedge clock_in);
    end
  endtask

  task automatic reset_and_init();
    int n;
    @(posedge clock_in);
    srst_in <= 1'b1;
    repeat (6) @(posedge clock_in);
    @(negedge clock_in);
    cmp_bit(i_burst_sram_if.rdata_oe_n, 1'b1);
    cmp_word(i_burst_sram_if.rdata, '0);
    cmp_bit(i_burst_sram_if.fetch_sel_n & i_burst_sram_if.store_sel_n, 1'b1);
    cmp_bit(init_done_out, 1'b0);
    @(posedge clock_in);
    srst_in <= 1'b0;
    for (n = 0; n < 2000 && init_done_out !== 1'b1; n++) @(negedge clock_in);
    expire(n);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    reset_and_init();
    cmp_bit(i_burst_sram_if.pll_off_n, 1'b1);
    for (int i = 0; i <= 10; i++) begin
      send(rows[i]);
      if (!rows[i].wr) take(rows[i].a);
    end
    // receiver stalls: both words wait in the buffer, new requests refused
    @(posedge clock_in);
    rd_ready_in <= 1'b0;
    send(rows[9]);
    for (n = 0; n < 2000 && rd_valid_out !== 1'b1; n++) @(negedge clock_in);
    expire(n);
    repeat (24) @(negedge clock_in);
    cmp_bit(rd_valid_out, 1'b1);
    cmp_bit(req_ready_out, 1'b0);
    @(posedge clock_in);
    rd_ready_in <= 1'b1;
    take(8'h02);
    repeat (30) @(negedge clock_in);
    cmp_bit(rd_valid_out, 1'b0);
    // reset in mid-run, then a fresh write and read
    reset_and_init();
    send('{1'b1, 8'h10, 72'h0123456789ABCDEF01, 8'h00});
    send('{1'b0, 8'h10, 72'h0, 8'h00});
    take(8'h10);
    give_verdict();
  end
endmodule
